// ===== logic/apm_consts.svh
// constants for the power switch and pin select block
`ifndef APM_CONSTS_SVH
`define APM_CONSTS_SVH
`define CFG_RING_LSB   1
`define CFG_IRQ_LSB    3
`define CFG_SUPPLY_BIT 5
`define CFG_SWITCH_LSB 6
`define CFG_RESET_VAL  8'h00
`endif

// ===== logic/apm_pkg.sv
// types for the power switch and pin select block
package apm_pkg;
  typedef enum logic [1:0] {
    SEL_NATIVE = 2'b00,
    SEL_GPIO   = 2'b01,
    SEL_KBD    = 2'b10,
    SEL_UART_C = 2'b11
  } pin_sel_t;
  typedef enum logic [0:0] {
    PWR_OFF = 1'b0,
    PWR_ON  = 1'b1
  } pwr_state_t;
endpackage : apm_pkg

// ===== logic/sync_fall.sv
// two-stage synchroniser with falling edge detect
`timescale 1ns/1ps
module sync_fall (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic s1_nxt;
  logic s2_nxt;
  logic s3_nxt;
  always_comb begin
    s1_nxt = pin_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end
  // idle level is high so reset does not fake an edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end
  assign fall = s3_r & ~s2_r;
endmodule : sync_fall

// ===== logic/apm_power_switch_pin_select.sv
// power management on/off control and pin role selection
`timescale 1ns/1ps
`include "apm_consts.svh"
module apm_power_switch_pin_select (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] pin_select_cfg_b,
  input  wire logic       main_supply_present,
  input  wire logic       power_off_req,
  input  wire logic       phone_ring_in,
  input  wire logic       panel_switch_in,
  input  wire logic [3:0] gpio2_out,
  input  wire logic       kbd_port_bit6,
  output logic            supply_on_ctl,
  output logic            power_off_irq,
  output logic            pin70_out,
  output logic            pin72_out,
  output logic            gpio2_bit0,
  output logic            gpio2_bit3,
  output logic            uart_c_ring_in,
  output logic            uart_c_carrier_in,
  output logic            pwr_on_req,
  output logic            pwr_off_req
);
  logic                ring_fall;
  logic                sw_fall;
  apm_pkg::pin_sel_t   ring_sel;
  apm_pkg::pin_sel_t   irq_sel;
  apm_pkg::pin_sel_t   sw_sel;
  logic                supply_sel;
  logic                ring_native;
  logic                sw_native;
  logic                irq_native;
  logic                switch_off_evt;
  apm_pkg::pwr_state_t pwr_r;
  apm_pkg::pwr_state_t pwr_nxt;

  logic                ring_s_r;
  logic                ring_s_nxt;
  logic                ring_s2_r;
  logic                ring_s2_nxt;
  logic                sw_s_r;
  logic                sw_s_nxt;
  logic                sw_s2_r;
  logic                sw_s2_nxt;

  logic                supply_on_ctl_r;
  logic                supply_on_ctl_nxt;
  logic                power_off_irq_r;
  logic                power_off_irq_nxt;
  logic                pin70_out_r;
  logic                pin70_out_nxt;
  logic                pin72_out_r;
  logic                pin72_out_nxt;
  logic                gpio2_bit0_r;
  logic                gpio2_bit0_nxt;
  logic                gpio2_bit3_r;
  logic                gpio2_bit3_nxt;
  logic                uart_c_ring_in_r;
  logic                uart_c_ring_in_nxt;
  logic                uart_c_carrier_in_r;
  logic                uart_c_carrier_in_nxt;
  logic                pwr_on_req_r;
  logic                pwr_on_req_nxt;
  logic                pwr_off_req_r;
  logic                pwr_off_req_nxt;

  // ring pin also feeds gpio, so level syncs kept apart from edge syncs
  sync_fall u_ring (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (phone_ring_in),
    .fall     (ring_fall)
  );
  sync_fall u_sw (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (panel_switch_in),
    .fall     (sw_fall)
  );

  always_comb begin
    ring_sel   = apm_pkg::pin_sel_t'(pin_select_cfg_b[`CFG_RING_LSB +: 2]);
    irq_sel    = apm_pkg::pin_sel_t'(pin_select_cfg_b[`CFG_IRQ_LSB +: 2]);
    sw_sel     = apm_pkg::pin_sel_t'(pin_select_cfg_b[`CFG_SWITCH_LSB +: 2]);
    supply_sel = pin_select_cfg_b[`CFG_SUPPLY_BIT];
  end

  always_comb begin
    ring_native = (ring_sel == apm_pkg::SEL_NATIVE);
    sw_native   = (sw_sel == apm_pkg::SEL_NATIVE);
    irq_native  = (irq_sel == apm_pkg::SEL_NATIVE);
  end

  // power state machine; ring wakes only, panel switch acts by supply state
  always_comb begin
    pwr_nxt        = pwr_r;
    switch_off_evt = 1'b0;
    case (pwr_r)
      apm_pkg::PWR_OFF: begin
        if (ring_native && ring_fall) begin
          pwr_nxt = apm_pkg::PWR_ON;
        end
        if (sw_native && sw_fall && !main_supply_present) begin
          pwr_nxt = apm_pkg::PWR_ON;
        end
      end
      apm_pkg::PWR_ON: begin
        if (sw_native && sw_fall && main_supply_present) begin
          switch_off_evt = 1'b1;
        end
        // supply only drops once the host accepts the request
        if (power_off_req) begin
          pwr_nxt = apm_pkg::PWR_OFF;
        end
      end
      default: begin
        pwr_nxt = apm_pkg::PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pwr_r <= apm_pkg::PWR_OFF;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // level copies for the gpio and uart roles, idle high like the pins
  always_comb begin
    ring_s_nxt  = phone_ring_in;
    ring_s2_nxt = ring_s_r;
    sw_s_nxt    = panel_switch_in;
    sw_s2_nxt   = sw_s_r;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ring_s_r  <= 1'b1;
      ring_s2_r <= 1'b1;
      sw_s_r    <= 1'b1;
      sw_s2_r   <= 1'b1;
    end else begin
      ring_s_r  <= ring_s_nxt;
      ring_s2_r <= ring_s2_nxt;
      sw_s_r    <= sw_s_nxt;
      sw_s2_r   <= sw_s2_nxt;
    end
  end

  // every pin value is registered so the outputs never glitch on a cfg write
  always_comb begin
    supply_on_ctl_nxt = (pwr_r == apm_pkg::PWR_ON);
    power_off_irq_nxt = switch_off_evt & irq_native;
    case (irq_sel)
      apm_pkg::SEL_NATIVE: pin70_out_nxt = switch_off_evt;
      apm_pkg::SEL_GPIO:   pin70_out_nxt = gpio2_out[1];
      apm_pkg::SEL_KBD:    pin70_out_nxt = kbd_port_bit6;
      default:             pin70_out_nxt = 1'b0;
    endcase
    if (supply_sel) begin
      pin72_out_nxt = gpio2_out[2];
    end else begin
      pin72_out_nxt = (pwr_r == apm_pkg::PWR_ON);
    end
    gpio2_bit0_nxt        = (ring_sel == apm_pkg::SEL_GPIO) ? ring_s2_r : 1'b0;
    gpio2_bit3_nxt        = (sw_sel == apm_pkg::SEL_GPIO) ? sw_s2_r : 1'b0;
    uart_c_ring_in_nxt    = (irq_sel == apm_pkg::SEL_UART_C) ? ring_s2_r : 1'b1;
    uart_c_carrier_in_nxt = (sw_sel == apm_pkg::SEL_UART_C) ? sw_s2_r : 1'b1;
    pwr_on_req_nxt        = (pwr_r == apm_pkg::PWR_OFF) && (pwr_nxt == apm_pkg::PWR_ON);
    pwr_off_req_nxt       = switch_off_evt;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      supply_on_ctl_r     <= 1'b0;
      power_off_irq_r     <= 1'b0;
      pin70_out_r         <= 1'b0;
      pin72_out_r         <= 1'b0;
      gpio2_bit0_r        <= 1'b0;
      gpio2_bit3_r        <= 1'b0;
      uart_c_ring_in_r    <= 1'b1;
      uart_c_carrier_in_r <= 1'b1;
      pwr_on_req_r        <= 1'b0;
      pwr_off_req_r       <= 1'b0;
    end else begin
      supply_on_ctl_r     <= supply_on_ctl_nxt;
      power_off_irq_r     <= power_off_irq_nxt;
      pin70_out_r         <= pin70_out_nxt;
      pin72_out_r         <= pin72_out_nxt;
      gpio2_bit0_r        <= gpio2_bit0_nxt;
      gpio2_bit3_r        <= gpio2_bit3_nxt;
      uart_c_ring_in_r    <= uart_c_ring_in_nxt;
      uart_c_carrier_in_r <= uart_c_carrier_in_nxt;
      pwr_on_req_r        <= pwr_on_req_nxt;
      pwr_off_req_r       <= pwr_off_req_nxt;
    end
  end

  assign supply_on_ctl     = supply_on_ctl_r;
  assign power_off_irq     = power_off_irq_r;
  assign pin70_out         = pin70_out_r;
  assign pin72_out         = pin72_out_r;
  assign gpio2_bit0        = gpio2_bit0_r;
  assign gpio2_bit3        = gpio2_bit3_r;
  assign uart_c_ring_in    = uart_c_ring_in_r;
  assign uart_c_carrier_in = uart_c_carrier_in_r;
  assign pwr_on_req        = pwr_on_req_r;
  assign pwr_off_req       = pwr_off_req_r;

endmodule : apm_power_switch_pin_select

// ===== sim/apm_power_switch_pin_select_asserts.sv
// assertions for the power switch and pin select block
`timescale 1ns/1ps
module apm_power_switch_pin_select_asserts (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [7:0] pin_select_cfg_b,
  input wire logic       main_supply_present,
  input wire logic       phone_ring_in,
  input wire logic       panel_switch_in,
  input wire logic       supply_on_ctl,
  input wire logic       power_off_irq,
  input wire logic       pin72_out,
  input wire logic       pwr_on_req
);
  wire logic [7:0] c = pin_select_cfg_b;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence sw_fall; $fell(panel_switch_in) && c[7:6] == 2'h0; endsequence
  a_switch_on: assert property (sw_fall ##0 !main_supply_present && !supply_on_ctl
    |-> ##[2:8] supply_on_ctl) else $error("no switch-on");
  a_switch_off: assert property (sw_fall ##0 main_supply_present && supply_on_ctl
    && c[4:3] == 2'h0 |-> ##[2:8] power_off_irq) else $error("no off irq");
  a_ring_on: assert property ($fell(phone_ring_in) && c[2:1] == 2'h0 && !supply_on_ctl
    |-> ##[2:8] supply_on_ctl) else $error("no ring turn-on");
  // edges must pass the synchroniser, so no request can follow at once
  a_sync_delay: assert property ($fell(panel_switch_in) |=> !pwr_on_req [*2])
    else $error("edge not synchronised");
  a_on_cause: assert property ($rose(supply_on_ctl) |-> $past(pwr_on_req))
    else $error("turn-on without request");
  a_role_refused: assert property (c[2:1] != 2'h0 && c[7:6] != 2'h0 |=> !pwr_on_req)
    else $error("request from foreign role");
  a_irq_role: assert property (power_off_irq |-> $past(c[4:3]) == 2'h0)
    else $error("irq in foreign role");
  a_supply_pin: assert property ($stable(c) && !c[5] |-> pin72_out == supply_on_ctl)
    else $error("supply pin mismatch");
endmodule : apm_power_switch_pin_select_asserts
bind apm_power_switch_pin_select apm_power_switch_pin_select_asserts asserts_i (
  .core_clk, .reset, .pin_select_cfg_b, .main_supply_present, .phone_ring_in,
  .panel_switch_in, .supply_on_ctl, .power_off_irq, .pin72_out, .pwr_on_req);

// ===== sim/apm_partner.sv
// panel switch, ring line and main supply model
`timescale 1ns/1ps
module apm_partner (
  input  wire logic supply_on_ctl,
  input  wire logic press,
  input  wire logic ring,
  output logic      panel_switch_in,
  output logic      phone_ring_in,
  output logic      main_supply_present
);
  // lines idle high; a prompt supply keeps the test short
  assign panel_switch_in     = !press;
  assign phone_ring_in       = !ring;
  assign main_supply_present = supply_on_ctl;
endmodule : apm_partner

// ===== sim/apm_power_switch_pin_select_tb.sv
// bench for the power switch and pin select block
`timescale 1ns/1ps
module apm_power_switch_pin_select_tb;
  logic core_clk, reset, press, ring, ack, sw, ri, vdd, son, irq, p70, p72;
  logic g0, g3, ucr, ucd, poff;
  logic [7:0] cfg;
  int         err_count, num_checks;
  apm_partner apm_partner_i (.supply_on_ctl(son), .press, .ring,
    .panel_switch_in(sw), .phone_ring_in(ri), .main_supply_present(vdd));
  apm_power_switch_pin_select apm_power_switch_pin_select_i (.core_clk, .reset,
    .pin_select_cfg_b(cfg), .main_supply_present(vdd), .power_off_req(ack),
    .phone_ring_in(ri), .panel_switch_in(sw), .gpio2_out(4'h2), .kbd_port_bit6(1'b1),
    .supply_on_ctl(son), .power_off_irq(irq), .pin70_out(p70), .pin72_out(p72),
    .gpio2_bit0(g0), .gpio2_bit3(g3), .uart_c_ring_in(ucr), .uart_c_carrier_in(ucd),
    .pwr_on_req(), .pwr_off_req(poff));
  initial begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %b got %b", n, e, s);
    end
  endtask : chk
  task automatic wait_for(input string n, ref logic s, input logic v);
    for (int i = 0; i < 20 && s !== v; i++) @(posedge core_clk);
    chk(n, v, s);
    if (s !== v) final_report();
  endtask : wait_for
  // held two cycles so the synchroniser cannot miss it
  task automatic push(input logic r);
    @(posedge core_clk);
    {press, ring} <= {!r, r};
    repeat (2) @(posedge core_clk);
    {press, ring} <= 2'h0;
  endtask : push
  initial begin
    {reset, press, ring, ack, cfg} = {4'h8, 8'h00};
    repeat (2) @(posedge core_clk);
    reset <= 0;
    chk("supply", 0, son);
    push(0);
    wait_for("switch on", son, 1);
    chk("supply pin", 1, p72);
    push(0);
    wait_for("off irq", irq, 1);
    chk("off req", 1, poff);
    @(posedge core_clk) ack <= 1;
    @(posedge core_clk) ack <= 0;
    wait_for("supply off", son, 0);
    cfg <= 8'h42;
    push(0);
    push(1);
    repeat (8) @(posedge core_clk);
    chk("refused", 0, son);
    chk("gpio ring", 1, g0);
    chk("gpio switch", 1, g3);
    cfg <= 8'h00;
    push(1);
    wait_for("ring on", son, 1);
    chk("gpio ring off", 0, g0);
    for (int k = 0; k < 4; k++) begin
      cfg <= 8'(k << 3);
      repeat (3) @(posedge core_clk);
      chk("irq pin", k == 1 || k == 2, p70);
    end
    cfg <= 8'hd8;
    push(0);
    repeat (2) @(negedge core_clk);
    chk("uart carrier", 0, ucd);
    push(1);
    repeat (2) @(negedge core_clk);
    chk("uart ring", 0, ucr);
    @(posedge core_clk);
    cfg <= 8'h20;
    repeat (3) @(posedge core_clk);
    chk("supply pin gpio", 0, p72);
    final_report();
  end
endmodule : apm_power_switch_pin_select_tb
